// *** design/t1np_pkg.sv ***
// Package with the map, field layout, reset values and carrier types of the next page registers.
package t1np_pkg;

    // ************************************************************
    // Register indices; the byte address on the bus is four times the index.
    // ************************************************************
    localparam logic [9:0] IDX_PB_LOW = 10'h206;
    localparam logic [9:0] IDX_PB_HIGH = 10'h207;
    localparam logic [9:0] IDX_NP_LOW = 10'h208;
    localparam logic [9:0] IDX_NP_MID = 10'h209;
    localparam logic [9:0] IDX_NP_HIGH = 10'h20A;
    localparam logic [9:0] IDX_LVL_CTRL = 10'h210;

    // ************************************************************
    // Field positions.
    // ************************************************************
    localparam int PB_HI_EEE_BIT = 14;
    localparam int PB_HI_ABLE_BIT = 13;
    localparam int PB_HI_REQ_BIT = 12;
    localparam int PB_HI_HD_BIT = 11;
    localparam int NP_MORE_BIT = 15;
    localparam int NP_ACK_BIT = 14;
    localparam int NP_ENC_BIT = 13;
    localparam int NP_COMPLY_BIT = 12;
    localparam int NP_FLIP_BIT = 11;
    localparam int LVL_LOCAL_REQ_BIT = 12;

    // ************************************************************
    // Masks and reset values.
    // ************************************************************
    localparam logic [15:0] PB_HI_MASK = 16'h7800;
    localparam logic [15:0] NP_LOW_WMASK = 16'hB7FF;
    localparam logic [15:0] LVL_WMASK = 16'h1000;
    localparam logic [15:0] NP_LOW_RST = 16'h2001;
    localparam logic [15:0] NP_MID_RST = 16'h0000;
    localparam logic [15:0] NP_HIGH_RST = 16'h0000;
    localparam logic [15:0] LVL_RST = 16'h0000;
    localparam logic [15:0] PB_HIGH_RST = 16'h0000;

    // ************************************************************
    // Carrier types.
    // ************************************************************
    typedef struct packed {
        logic [15:0] high;
        logic [15:0] low;
    } t1np_partner_s;

    typedef struct packed {
        logic [15:0] high;
        logic [15:0] mid;
        logic [15:0] low;
    } t1np_page_s;

    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic [15:0] pb_high;
        logic [15:0] np_low;
        logic [15:0] np_mid;
        logic [15:0] np_high;
        logic [15:0] lvl;
        logic np_ack;
        logic flip;
        t1np_page_s page;
        logic page_valid;
        logic level_sel;
    } t1np_state_s;

endpackage : t1np_pkg

// *** design/t1np_regs.sv ***
// Next page transmit and partner ability registers behind a classic Wishbone slave.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Read-only flag shows partner ability to transmit at the 2.4 V p-p level.
// - Partner ability, partner request and the local request bit together pick 2.4 V or 1.0 V level.
// - Read-only flag shows partner request for the high level; resets to zero.
// - Read-only flag shows partner half-duplex short-reach ability; resets to zero.
// - Power-up or autonegotiation reset returns the low word to a null message page.
// - Writable request bit tells the partner another page follows; resets to zero.
// - Acknowledge bit is read-only, resets to zero and is managed by hardware.
// - Writable encoding bit: 0 unformatted, 1 message page; resets to one.
// - Toggle bit reads zero; hardware sets it to keep pages in step.
// - Eleven-bit writable code field, reset to 1: 1 null, 5 tagged, 6 identifier.
// - Reading the low ability word latches the high word; high reads the copy.
module t1np_regs (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic an_reset_i,
    input wire logic base_toggle_i,
    input wire t1np_pkg::t1np_partner_s partner_ability_i,
    input wire logic partner_ack_i,
    output t1np_pkg::t1np_page_s np_page_o,
    output logic np_page_valid_o,
    output logic high_level_select_o
);

    // ************************************************************
    // Helpers.
    // ************************************************************

    // Byte-lane merge of a 16-bit register, limited to its writable bits.
    function automatic logic [15:0] t1np_merge(
        input logic [15:0] old,
        input logic [15:0] wdat,
        input logic [1:0] sel,
        input logic [15:0] wmask
    );
        logic [15:0] lane;
        lane = {{8{sel[1]}}, {8{sel[0]}}} & wmask;
        t1np_merge = (old & ~lane) | (wdat & lane);
    endfunction : t1np_merge

    // Widen a 16-bit register into the low half of a bus word.
    function automatic logic [31:0] t1np_word(input logic [15:0] val);
        t1np_word = {16'h0000, val};
    endfunction : t1np_word

    // ************************************************************
    // State.
    // ************************************************************
    t1np_pkg::t1np_state_s state_q;
    t1np_pkg::t1np_state_s state_d;
    logic [9:0] idx;
    logic req;
    logic wr_go;
    logic rd_go;
    logic [31:0] rd_mux;
    logic [15:0] np_low_view;
    logic [15:0] new_low;

    assign idx = wb_adr_i[11:2];
    assign req = wb_cyc_i & wb_stb_i;
    // A write lands, and a read side effect fires, only at the edge the master sees ack.
    assign wr_go = req & state_q.ack & wb_we_i;
    assign rd_go = req & state_q.ack & ~wb_we_i;

    // ************************************************************
    // Read view.
    // ************************************************************

    // The toggle is never stored in the software copy, so it always reads zero.
    always_comb begin
        np_low_view = state_q.np_low;
        np_low_view[t1np_pkg::NP_ACK_BIT] = state_q.np_ack;
        np_low_view[t1np_pkg::NP_FLIP_BIT] = 1'b0;
    end

    always_comb begin
        case (idx)
            t1np_pkg::IDX_PB_LOW: begin
                rd_mux = t1np_word(partner_ability_i.low);
            end
            t1np_pkg::IDX_PB_HIGH: begin
                rd_mux = t1np_word(state_q.pb_high);
            end
            t1np_pkg::IDX_NP_LOW: begin
                rd_mux = t1np_word(np_low_view);
            end
            t1np_pkg::IDX_NP_MID: begin
                rd_mux = t1np_word(state_q.np_mid);
            end
            t1np_pkg::IDX_NP_HIGH: begin
                rd_mux = t1np_word(state_q.np_high);
            end
            t1np_pkg::IDX_LVL_CTRL: begin
                rd_mux = t1np_word(state_q.lvl);
            end
            default: begin
                rd_mux = 32'h00000000;
            end
        endcase
    end

    // ************************************************************
    // Next state.
    // ************************************************************
    always_comb begin
        new_low = t1np_merge(state_q.np_low, wb_dat_i[15:0], wb_sel_i[1:0],
                             t1np_pkg::NP_LOW_WMASK);
        state_d = state_q;
        state_d.ack = 1'b0;
        state_d.page_valid = 1'b0;

        // Bus answer: one cycle of ack, then ack drops for the released cycle.
        if (req && !state_q.ack) begin
            state_d.ack = 1'b1;
            state_d.rdat = rd_mux;
        end

        // The high ability word is a snapshot taken when software reads the low word.
        if (rd_go && idx == t1np_pkg::IDX_PB_LOW) begin
            state_d.pb_high = partner_ability_i.high & t1np_pkg::PB_HI_MASK;
        end

        if (wr_go) begin
            case (idx)
                t1np_pkg::IDX_NP_MID: begin
                    state_d.np_mid = t1np_merge(state_q.np_mid, wb_dat_i[15:0],
                                                wb_sel_i[1:0], 16'hFFFF);
                end
                t1np_pkg::IDX_NP_HIGH: begin
                    state_d.np_high = t1np_merge(state_q.np_high, wb_dat_i[15:0],
                                                 wb_sel_i[1:0], 16'hFFFF);
                end
                t1np_pkg::IDX_LVL_CTRL: begin
                    state_d.lvl = t1np_merge(state_q.lvl, wb_dat_i[15:0],
                                             wb_sel_i[1:0], t1np_pkg::LVL_WMASK);
                end
                t1np_pkg::IDX_NP_LOW: begin
                    // Writing the low word completes the page, so the other two
                    // words must already hold their final contents.
                    state_d.np_low = new_low;
                    state_d.page.high = state_q.np_high;
                    state_d.page.mid = state_q.np_mid;
                    state_d.page.low = new_low;
                    state_d.page.low[t1np_pkg::NP_ACK_BIT] = state_q.np_ack;
                    state_d.page.low[t1np_pkg::NP_FLIP_BIT] = state_q.flip;
                    state_d.page_valid = 1'b1;
                    state_d.flip = ~state_q.flip;
                    state_d.np_ack = 1'b0;
                end
                default: begin
                    state_d.np_low = state_q.np_low;
                end
            endcase
        end

        // A partner acknowledge in the same cycle as a new page still sticks.
        if (partner_ack_i) begin
            state_d.np_ack = 1'b1;
        end

        // Transmit level: high only when both partner bits and the local request agree.
        state_d.level_sel = partner_ability_i.high[t1np_pkg::PB_HI_ABLE_BIT]
                          & partner_ability_i.high[t1np_pkg::PB_HI_REQ_BIT]
                          & state_q.lvl[t1np_pkg::LVL_LOCAL_REQ_BIT];

        // Autonegotiation reset restores the page words and reseeds the toggle.
        if (an_reset_i) begin
            state_d.np_low = t1np_pkg::NP_LOW_RST;
            state_d.np_mid = t1np_pkg::NP_MID_RST;
            state_d.np_high = t1np_pkg::NP_HIGH_RST;
            state_d.np_ack = 1'b0;
            state_d.flip = ~base_toggle_i;
            state_d.page_valid = 1'b0;
        end
    end

    // ************************************************************
    // Registers.
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q.ack <= 1'b0;
            state_q.rdat <= 32'h00000000;
            state_q.pb_high <= t1np_pkg::PB_HIGH_RST;
            state_q.np_low <= t1np_pkg::NP_LOW_RST;
            state_q.np_mid <= t1np_pkg::NP_MID_RST;
            state_q.np_high <= t1np_pkg::NP_HIGH_RST;
            state_q.lvl <= t1np_pkg::LVL_RST;
            state_q.np_ack <= 1'b0;
            state_q.flip <= 1'b0;
            state_q.page <= '0;
            state_q.page_valid <= 1'b0;
            state_q.level_sel <= 1'b0;
        end else begin
            state_q <= state_d;
        end
    end

    assign wb_ack_o = state_q.ack;
    assign wb_dat_o = state_q.rdat;
    assign np_page_o = state_q.page;
    assign np_page_valid_o = state_q.page_valid;
    assign high_level_select_o = state_q.level_sel;

endmodule : t1np_regs

`default_nettype wire

// *** sim/t1np_assertions.sv ***
// Checker of the next page register block, bound to its ports.
`timescale 1ns/1ps
`default_nettype none
module t1np_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic an_reset_i,
    input wire t1np_pkg::t1np_partner_s partner_ability_i,
    input wire t1np_pkg::t1np_page_s np_page_o,
    input wire logic np_page_valid_o,
    input wire logic high_level_select_o
);
    logic rd_ack;
    logic wr_low;
    assign rd_ack = wb_ack_o && wb_cyc_i && !wb_we_i;
    assign wr_low = wb_ack_o && wb_cyc_i && wb_we_i && wb_adr_i[11:2] == t1np_pkg::IDX_NP_LOW;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_page_cause: assert property (np_page_valid_o |-> $past(wr_low))
        else $error("page valid without low word write");
    a_page_given: assert property (wr_low && !an_reset_i |=> np_page_valid_o)
        else $error("low word write gave no page");
    a_page_pulse: assert property (np_page_valid_o |=> !np_page_valid_o)
        else $error("page valid longer than one cycle");
    a_page_fields: assert property (np_page_valid_o && $past(wb_sel_i[1:0]) == 2'b11 |->
        (np_page_o.low & t1np_pkg::NP_LOW_WMASK) ==
        ($past(wb_dat_i[15:0]) & t1np_pkg::NP_LOW_WMASK)) else $error("page fields differ");
    a_anreset_cancel: assert property (an_reset_i |=> !np_page_valid_o)
        else $error("page survived autonegotiation reset");
    a_flip_hidden: assert property (rd_ack && wb_adr_i[11:2] == t1np_pkg::IDX_NP_LOW |->
        !wb_dat_o[t1np_pkg::NP_FLIP_BIT]) else $error("toggle bit visible");
    a_upper_bits: assert property (rd_ack && wb_adr_i[11:2] == t1np_pkg::IDX_PB_HIGH |->
        (wb_dat_o & ~{16'h0000, t1np_pkg::PB_HI_MASK}) == 32'h00000000)
        else $error("reserved ability bits set");
    a_level_cause: assert property (high_level_select_o |->
        $past(partner_ability_i.high[t1np_pkg::PB_HI_ABLE_BIT] &&
        partner_ability_i.high[t1np_pkg::PB_HI_REQ_BIT]))
        else $error("high level chosen without partner");
    cover property (np_page_valid_o);
    cover property (high_level_select_o);
    cover property (an_reset_i ##[1:40] wr_low);
endmodule : t1np_checker
bind t1np_regs t1np_checker u_t1np_checker (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .an_reset_i, .partner_ability_i,
    .np_page_o, .np_page_valid_o, .high_level_select_o);
`default_nettype wire

// *** sim/t1np_partner.sv ***
// Model of the remote PHY: shows its ability words and acknowledges each page.
`timescale 1ns/1ps
`default_nettype none
module t1np_partner (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic np_page_valid_i,
    input wire logic [3:0] dly_i,
    input wire t1np_pkg::t1np_partner_s adv_i,
    output var t1np_pkg::t1np_partner_s partner_ability_o,
    output logic partner_ack_o
);
    logic [4:0] cnt_q;
    assign partner_ability_o = adv_i;
    // The delay varies per page so both a prompt and a slow partner are seen.
    always_ff @(posedge clk_i) begin
        if (rst_i) cnt_q <= 5'h00;
        else if (np_page_valid_i) cnt_q <= {1'b0, dly_i} + 5'h01;
        else if (cnt_q != 5'h00) cnt_q <= cnt_q - 5'h01;
    end
    assign partner_ack_o = (cnt_q == 5'h01);
endmodule : t1np_partner
`default_nettype wire

// *** sim/testbench.sv ***
// Self-checking bench of the next page register block with a remote PHY model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_i, rst_i, req, we, ack, an_rst, base_tg, valid, lvl, p_ack, tg, ackb;
    logic [11:0] adr;
    logic [3:0] sel, dly;
    logic [31:0] wdat, rdat;
    logic [15:0] q, w, m, h;
    t1np_pkg::t1np_partner_s adv, pab;
    t1np_pkg::t1np_page_s page;
    int seed = 91;
    int bad_count = 0;
    int n_compared = 0;
    t1np_regs u_t1np_regs (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .an_reset_i(an_rst), .base_toggle_i(base_tg),
        .partner_ability_i(pab), .partner_ack_i(p_ack), .np_page_o(page),
        .np_page_valid_o(valid), .high_level_select_o(lvl));
    t1np_partner u_t1np_partner (.clk_i(clk_i), .rst_i(rst_i), .np_page_valid_i(valid),
        .dly_i(dly), .adv_i(adv), .partner_ability_o(pab), .partner_ack_o(p_ack));
    task automatic chk(input string what, input logic [47:0] e, input logic [47:0] s);
        n_compared++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, e, s);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [9:0] i, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        req <= 1'b1;
        we <= wr;
        adr <= {i, 2'b00};
        wdat <= {16'h0000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat[15:0];
        req <= 1'b0;
        chk("bus ack", 48'h1, {47'h0, ack});
    endtask : bus
    task automatic np_page(input logic [15:0] lw);
        int n;
        m = 16'($random(seed));
        h = 16'($random(seed));
        bus(1'b1, t1np_pkg::IDX_NP_MID, m);
        bus(1'b1, t1np_pkg::IDX_NP_HIGH, h);
        bus(1'b1, t1np_pkg::IDX_NP_LOW, lw);
        n = 0;
        while (valid !== 1'b1 && n < 4) begin
            @(posedge clk_i);
            n++;
        end
        chk("page", {h, m, (lw & 16'hB7FF) | {1'b0, ackb, 2'b00, tg, 11'h000}}, page);
        tg = ~tg;
        n = 0;
        while (p_ack !== 1'b1 && n < 25) begin
            @(posedge clk_i);
            n++;
        end
        ackb = 1'b1;
        bus(1'b0, t1np_pkg::IDX_NP_LOW, 16'h0000);
        chk("low readback", (lw & 16'hB7FF) | 16'h4000, q);
    endtask : np_page
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    initial begin
        #200000;
        bad_count++;
        wrap_up();
    end
    initial begin
        {rst_i, req, we, an_rst, base_tg, tg, ackb} = 7'h40;
        {adr, wdat, adv, dly} = '0;
        sel = 4'hF;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, t1np_pkg::IDX_NP_LOW, 16'h0000);
        chk("low reset", t1np_pkg::NP_LOW_RST, q);
        bus(1'b0, t1np_pkg::IDX_PB_HIGH, 16'h0000);
        chk("ability reset", 48'h0, q);
        $display("test reset done");
        bus(1'b1, t1np_pkg::IDX_LVL_CTRL, 16'h1000);
        for (int k = 0; k < 6; k++) begin
            w = 16'($random(seed));
            w[13:12] = k[1:0];
            adv <= {w, 16'($random(seed))};
            repeat (2) @(posedge clk_i);
            chk("level", {47'h0, w[13] & w[12]}, {47'h0, lvl});
            bus(1'b0, t1np_pkg::IDX_PB_LOW, 16'h0000);
            adv.high <= ~w;
            bus(1'b0, t1np_pkg::IDX_PB_HIGH, 16'h0000);
            chk("snapshot", w & t1np_pkg::PB_HI_MASK, q);
        end
        bus(1'b1, t1np_pkg::IDX_LVL_CTRL, 16'h0000);
        repeat (2) @(posedge clk_i);
        chk("level off", 48'h0, {47'h0, lvl});
        $display("test ability done");
        for (int k = 0; k < 6; k++) begin
            w = 16'($random(seed));
            w[13] = k[0];
            if (k < 3) w[10:0] = (k == 0) ? 11'h001 : (k == 1) ? 11'h005 : 11'h006;
            dly <= 4'($random(seed));
            np_page(w);
        end
        bus(1'b1, 10'h3FF, 16'hFFFF);
        bus(1'b0, 10'h3FF, 16'h0000);
        chk("unmapped", 48'h0, q);
        $display("test pages done");
        base_tg <= 1'($random(seed));
        an_rst <= 1'b1;
        @(posedge clk_i);
        an_rst <= 1'b0;
        tg = ~base_tg;
        ackb = 1'b0;
        bus(1'b0, t1np_pkg::IDX_NP_LOW, 16'h0000);
        chk("low after an reset", t1np_pkg::NP_LOW_RST, q);
        bus(1'b0, t1np_pkg::IDX_NP_MID, 16'h0000);
        chk("mid after an reset", 48'h0, q);
        np_page(16'hA801);
        $display("test an reset done");
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
